// ==== hw/eeprom_protect_cfg.svh ====
`ifndef EEPROM_PROTECT_CFG_SVH
`define EEPROM_PROTECT_CFG_SVH

// Status byte field positions
`define STAT_PIN_PROTECT_EN_BIT 7
`define STAT_RSV_HI_BIT         6
`define STAT_RSV_LO_BIT         4
`define STAT_GUARD_HI_BIT       3
`define STAT_GUARD_LO_BIT       2
`define STAT_LATCH_BIT          1
`define STAT_BUSY_BIT           0

// Opcode matching: bit 3 is don't care
`define OPC_MASK        8'hF7
`define OPC_SET_LATCH   8'h06
`define OPC_CLR_LATCH   8'h04
`define OPC_READ_STATUS 8'h05
`define OPC_WRITE_STATUS 8'h01

// Factory values of the nonvolatile fields
`define NV_PROTECT_EN_RESET 1'b0
`define NV_GUARD_RESET      2'b00

// Internal write cycle time
`define WRITE_CYCLE_US      5000
`define CLK_MHZ             25
`define WRITE_CYCLE_CYCLES  (`WRITE_CYCLE_US * `CLK_MHZ)

`endif

// ==== hw/eeprom_protect_pkg.sv ====
package eeprom_protect_pkg;

  typedef enum logic [1:0] {
    ST_OPCODE = 2'b00,
    ST_DATA   = 2'b01,
    ST_SEND   = 2'b10,
    ST_IGNORE = 2'b11
  } frame_state_t;

  typedef struct packed {
    logic [2:0] cs_n;
    logic [2:0] sck;
    logic [2:0] si;
    logic [2:0] wp_n;
  } pin_sync_t;

  typedef struct packed {
    logic       protect_en;
    logic [1:0] guard;
  } nv_bits_t;

endpackage

// ==== hw/spi_eeprom_status_protect.sv ====
// What this block does
// RULE1 - Eight-bit status byte with fixed field layout
// RULE2 - Reserved bits read ones during write cycle
// RULE3 - Two guard bits select none, quarter, half, all
// RULE4 - 1 KiB part protects top quarter, half, all
// RULE5 - 2 KiB part protects top quarter, half, all
// RULE6 - Latch bit reads set when writes enabled
// RULE7 - Busy bit set during internal operation
// RULE8 - Opcode 05h shifts status byte out
// RULE9 - Opcode 06h then deselect sets latch
// RULE10 - Writes accepted only with latch set
// RULE11 - Opcode 04h clears latch regardless of pin
// RULE12 - Status write changes only bits 7,3,2
// RULE13 - Protect fields kept in nonvolatile cells
// RULE14 - Only status read accepted while busy
// RULE15 - Latch cleared when status write completes
// RULE16 - Write cycle starts at deselect edge
// RULE17 - Pin low and enable block status writes
// RULE18 - Otherwise only guard and latch gate writes
// RULE19 - Enable bit cannot clear while pin low
// RULE20 - Array and status write permission table
// RULE21 - Opcodes match with bit 3 ignored
// RULE22 - Pin fall during frame abandons status write
// RULE23 - One data byte follows write-status opcode
// RULE24 - Write-status without latch is discarded
`timescale 1ns/1ps
`include "eeprom_protect_cfg.svh"

module spi_eeprom_status_protect #(
  parameter int          ADDR_W       = 11,
  parameter int unsigned WRITE_CYCLES = `WRITE_CYCLE_CYCLES
) (
  input  wire logic              clk_sys_in,
  input  wire logic              reset_n_in,
  input  wire logic              spi_cs_n_in,
  input  wire logic              spi_sck_in,
  input  wire logic              spi_si_in,
  input  wire logic              protect_pin_n_in,
  output logic                   spi_so_out,
  output logic                   spi_so_oe_n_out,
  input  wire logic [ADDR_W-1:0] array_addr_in,
  input  wire logic              array_write_start_in,
  input  wire logic              array_write_done_in,
  output logic                   array_addr_writable_out,
  output logic                   busy_out,
  output logic                   write_enable_latch_out,
  output logic [7:0]             status_byte_out,
  output logic                   nv_write_strobe_out,
  output logic [2:0]             nv_write_data_out
);

  typedef struct packed {
    eeprom_protect_pkg::pin_sync_t    sync;
    eeprom_protect_pkg::frame_state_t state;
    logic [2:0]                       bit_cnt;
    logic [7:0]                       shift_in;
    logic [7:0]                       shift_out;
    logic                             so_drive;
    logic                             so_bit;
    logic                             wsr_armed;
    logic                             set_pending;
    logic [2:0]                       wsr_data;
    eeprom_protect_pkg::nv_bits_t     nv;
    logic                             wr_latch;
    logic                             st_busy;
    logic                             arr_busy;
    logic [31:0]                      wc_cnt;
    logic                             nv_strobe;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  function automatic logic opc_is(input logic [7:0] b,
                                  input logic [7:0] code);
    opc_is = ((b & `OPC_MASK) == code); // RULE21
  endfunction

  // Protected region starts at a fraction of the array size;
  // the top address bits alone mark it for either array size
  function automatic logic addr_guarded(input logic [ADDR_W-1:0] a,
                                        input logic [1:0] g);
    logic top_half;
    logic top_quarter;
    top_half    = a[ADDR_W-1];
    top_quarter = a[ADDR_W-1] & a[ADDR_W-2];
    case (g) // RULE3
      2'b01: begin
        addr_guarded = top_quarter; // RULE4 RULE5
      end
      2'b10: begin
        addr_guarded = top_half; // RULE4 RULE5
      end
      2'b11: begin
        addr_guarded = 1'b1; // RULE4 RULE5
      end
      default: begin
        addr_guarded = 1'b0;
      end
    endcase
  endfunction

  // Only the three nonvolatile fields are taken from written data
  function automatic logic [2:0] keep_fields(input logic [7:0] b);
    keep_fields = {b[`STAT_PIN_PROTECT_EN_BIT],
                   b[`STAT_GUARD_HI_BIT],
                   b[`STAT_GUARD_LO_BIT]}; // RULE12
  endfunction

  // Reserved field reads ones during any internal write cycle
  function automatic logic [7:0] build_status(input logic       pe,
                                              input logic [1:0] g,
                                              input logic       wl,
                                              input logic       bz);
    build_status = {pe, {3{bz}}, g, wl, bz}; // RULE1 RULE2
  endfunction

  // Edge seen only when the second and third stages disagree
  function automatic logic edge_of(input logic now_v,
                                   input logic old_v,
                                   input logic rising);
    if (rising) begin
      edge_of = now_v & ~old_v;
    end else begin
      edge_of = ~now_v & old_v;
    end
  endfunction

  logic cs_n_s;
  logic cs_n_p;
  logic sck_s;
  logic sck_p;
  logic wp_n_s;
  logic wp_n_p;
  logic hw_protect;
  logic busy;
  logic sck_rise;
  logic sck_fall;
  logic cs_rise;
  logic cs_fall;
  logic wp_fall;
  logic [7:0] status_byte;
  logic [7:0] byte_in;
  logic       opc_read;
  logic       opc_set;
  logic       opc_clear;
  logic       opc_wstat;
  logic       status_wr_ok;
  logic       wstat_accept;
  logic       frame_whole;
  logic       wstat_start;
  logic       wstat_abandon;
  logic       cycle_done;
  logic       array_start_ok;
  logic       array_done_ok;
  logic [2:0] wstat_keep;
  logic       addr_in_guard;
  logic       array_allowed;

  // A change counts in the cycle the second and third stages differ
  always_comb begin
    cs_n_s  = st_r.sync.cs_n[1];
    cs_n_p  = st_r.sync.cs_n[2];
    sck_s   = st_r.sync.sck[1];
    sck_p   = st_r.sync.sck[2];
    wp_n_s  = st_r.sync.wp_n[1];
    wp_n_p  = st_r.sync.wp_n[2];
    sck_rise = edge_of(sck_s, sck_p, 1'b1) & ~cs_n_s;
    sck_fall = edge_of(sck_s, sck_p, 1'b0) & ~cs_n_s;
    cs_rise  = edge_of(cs_n_s, cs_n_p, 1'b1);
    cs_fall  = edge_of(cs_n_s, cs_n_p, 1'b0);
    wp_fall  = edge_of(wp_n_s, wp_n_p, 1'b0);
  end

  // Status view and protect level from the synced pin
  always_comb begin
    busy = st_r.st_busy | st_r.arr_busy;
    hw_protect = ~wp_n_s & st_r.nv.protect_en; // RULE17 RULE18
    status_byte = build_status(st_r.nv.protect_en, st_r.nv.guard,
                               st_r.wr_latch, busy); // RULE6 RULE7
    byte_in = {st_r.shift_in[6:0], st_r.sync.si[2]};
  end

  // Opcode decode of the byte completing at the eighth bit
  always_comb begin
    opc_read  = opc_is(byte_in, `OPC_READ_STATUS); // RULE8
    opc_set   = opc_is(byte_in, `OPC_SET_LATCH); // RULE9
    opc_clear = opc_is(byte_in, `OPC_CLR_LATCH); // RULE11
    opc_wstat = opc_is(byte_in, `OPC_WRITE_STATUS); // RULE21
  end

  // Status byte writable only with latch set and no pin protect
  always_comb begin
    status_wr_ok  = st_r.wr_latch & ~hw_protect; // RULE17 RULE19 RULE20
    wstat_accept  = opc_wstat & status_wr_ok; // RULE10 RULE24
    frame_whole   = (st_r.bit_cnt == 3'd0);
    // A cut data byte leaves the count mid-way, so nothing starts
    wstat_start   = cs_rise & st_r.wsr_armed & frame_whole &
                    status_wr_ok; // RULE16
    // Once the cycle runs, the pin no longer matters
    wstat_abandon = wp_fall & st_r.nv.protect_en & ~cs_n_s; // RULE22
    cycle_done    = st_r.st_busy &
                    (st_r.wc_cnt >= WRITE_CYCLES - 1); // RULE15
    array_start_ok = array_write_start_in & st_r.wr_latch & ~busy;
    array_done_ok  = array_write_done_in & st_r.arr_busy;
    wstat_keep     = keep_fields(byte_in); // RULE12
  end

  // Array writes: guarded never, open only with latch and idle
  always_comb begin
    addr_in_guard = addr_guarded(array_addr_in, st_r.nv.guard); // RULE3
    array_allowed = 1'b0;
    if (addr_in_guard) begin
      array_allowed = 1'b0; // RULE20
    end else if (st_r.wr_latch && !busy) begin
      array_allowed = 1'b1; // RULE10
    end
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.nv_strobe = 1'b0;
    st_nxt.sync.cs_n = {st_r.sync.cs_n[1:0], spi_cs_n_in};
    st_nxt.sync.sck  = {st_r.sync.sck[1:0], spi_sck_in};
    st_nxt.sync.si   = {st_r.sync.si[1:0], spi_si_in};
    st_nxt.sync.wp_n = {st_r.sync.wp_n[1:0], protect_pin_n_in};

    if (cs_fall) begin
      st_nxt.state = eeprom_protect_pkg::ST_OPCODE;
      st_nxt.bit_cnt = 3'd0;
      st_nxt.wsr_armed = 1'b0;
      st_nxt.set_pending = 1'b0;
    end else if (sck_rise) begin
      st_nxt.shift_in = byte_in;
      st_nxt.bit_cnt = st_r.bit_cnt + 3'd1;
      if (st_r.bit_cnt == 3'd7) begin
        case (st_r.state)
          eeprom_protect_pkg::ST_OPCODE: begin
            st_nxt.state = eeprom_protect_pkg::ST_IGNORE;
            if (opc_read) begin // RULE8
              st_nxt.state = eeprom_protect_pkg::ST_SEND;
              st_nxt.shift_out = status_byte;
            end else if (!busy) begin // RULE14
              if (opc_set) begin
                st_nxt.set_pending = 1'b1; // RULE9
              end else if (opc_clear) begin
                st_nxt.wr_latch = 1'b0; // RULE11
              end else if (wstat_accept) begin // RULE10 RULE24
                st_nxt.state = eeprom_protect_pkg::ST_DATA; // RULE23
              end
            end
          end
          eeprom_protect_pkg::ST_DATA: begin
            st_nxt.wsr_data = wstat_keep; // RULE12
            st_nxt.wsr_armed = 1'b1;
            st_nxt.state = eeprom_protect_pkg::ST_IGNORE;
          end
          default: begin
          end
        endcase
      end
    end

    if (sck_fall && st_r.state == eeprom_protect_pkg::ST_SEND) begin
      st_nxt.so_drive = 1'b1;
      st_nxt.so_bit = st_r.shift_out[7];
      st_nxt.shift_out = {st_r.shift_out[6:0], 1'b0};
    end

    // Pin falling mid-frame with the enable bit set abandons a pending status write
    if (wstat_abandon) begin
      st_nxt.wsr_armed = 1'b0; // RULE22
      if (st_r.state == eeprom_protect_pkg::ST_DATA) begin
        st_nxt.state = eeprom_protect_pkg::ST_IGNORE;
      end
    end

    if (cs_rise) begin
      st_nxt.so_drive = 1'b0;
      st_nxt.state = eeprom_protect_pkg::ST_IGNORE;
      if (st_r.set_pending && !busy) begin
        st_nxt.wr_latch = 1'b1; // RULE9
      end
      if (wstat_start) begin // RULE16 RULE20
        st_nxt.st_busy = 1'b1;
        st_nxt.wc_cnt = 32'd0;
      end
      st_nxt.wsr_armed = 1'b0;
      st_nxt.set_pending = 1'b0;
    end

    if (st_r.st_busy) begin
      if (cycle_done) begin
        st_nxt.st_busy = 1'b0;
        st_nxt.wr_latch = 1'b0; // RULE15
        // Pin fall after start has no effect
        st_nxt.nv.protect_en = st_r.wsr_data[2]; // RULE13
        st_nxt.nv.guard = st_r.wsr_data[1:0];
        st_nxt.nv_strobe = 1'b1;
      end else begin
        st_nxt.wc_cnt = st_r.wc_cnt + 32'd1;
      end
    end

    // Array write needs the latch; its end clears it as well
    if (array_start_ok) begin // RULE10
      st_nxt.arr_busy = 1'b1;
    end
    if (array_done_ok) begin
      st_nxt.arr_busy = 1'b0;
      st_nxt.wr_latch = 1'b0;
    end
  end

  // Nonvolatile fields reset to factory values; a real part reloads cells
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st_r <= '0;
      st_r.sync <= '1;
      st_r.state <= eeprom_protect_pkg::ST_IGNORE;
      st_r.nv.protect_en <= `NV_PROTECT_EN_RESET; // RULE13
      st_r.nv.guard <= `NV_GUARD_RESET; // RULE3
      st_r.wr_latch <= 1'b0; // RULE6
    end else begin
      st_r <= st_nxt;
    end
  end

  // Enable bit can only change via a write already gated by the pin
  always_comb begin
    spi_so_out = st_r.so_bit;
    spi_so_oe_n_out = ~st_r.so_drive;
    busy_out = busy; // RULE7
    write_enable_latch_out = st_r.wr_latch; // RULE6
    status_byte_out = status_byte;
    array_addr_writable_out = array_allowed; // RULE20
    nv_write_strobe_out = st_r.nv_strobe;
    nv_write_data_out = {st_r.nv.protect_en, st_r.nv.guard};
  end

endmodule

// ==== dv/spi_eeprom_status_protect_asserts.sv ====
`timescale 1ns/1ps
module spi_eeprom_status_protect_asserts #(
  parameter int ADDR_W = 11
) (
  input wire logic              clk_sys_in,
  input wire logic              reset_n_in,
  input wire logic              spi_cs_n_in,
  input wire logic [ADDR_W-1:0] array_addr_in,
  input wire logic              spi_so_oe_n_out,
  input wire logic              array_addr_writable_out,
  input wire logic              busy_out,
  input wire logic              write_enable_latch_out,
  input wire logic [7:0]        status_byte_out,
  input wire logic              nv_write_strobe_out,
  input wire logic [2:0]        nv_write_data_out
);
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!reset_n_in);
  sequence s_cycle_runs;
    busy_out [*8];
  endsequence
  a_rsv_mirror: assert property (status_byte_out[6:4] == {3{busy_out}})
    else $error("reserved bits differ from busy");
  a_flag_bits: assert property (status_byte_out[1:0] ==
    {write_enable_latch_out, busy_out}) else $error("flag bits wrong");
  a_guard_all: assert property (status_byte_out[3:2] == 2'b11
    |-> !array_addr_writable_out) else $error("full guard leaks");
  a_guard_qtr: assert property (status_byte_out[3:2] == 2'b01 &&
    array_addr_in[ADDR_W-1 -: 2] == 2'b11 |-> !array_addr_writable_out)
    else $error("quarter guard leaks");
  a_latch_gate: assert property (!write_enable_latch_out
    |-> !array_addr_writable_out) else $error("write without latch");
  a_open_write: assert property (status_byte_out[3:2] == 2'b00 &&
    write_enable_latch_out && !busy_out |-> array_addr_writable_out)
    else $error("unguarded address refused");
  a_cycle_len: assert property ($rose(busy_out)
    |-> s_cycle_runs ##[1:500] !busy_out) else $error("cycle length bad");
  a_end_clear: assert property ($fell(busy_out)
    |-> ##[0:2] !write_enable_latch_out) else $error("latch kept set");
  a_nv_commit: assert property (nv_write_strobe_out |=>
    {status_byte_out[7], status_byte_out[3:2]} == $past(nv_write_data_out))
    else $error("status not committed");
  a_so_idle: assert property (spi_cs_n_in [*6] |-> spi_so_oe_n_out)
    else $error("output driven while deselected");
endmodule
bind spi_eeprom_status_protect spi_eeprom_status_protect_asserts
  #(.ADDR_W(ADDR_W)) u_chk (.clk_sys_in(clk_sys_in),
  .reset_n_in(reset_n_in), .spi_cs_n_in(spi_cs_n_in),
  .array_addr_in(array_addr_in), .spi_so_oe_n_out(spi_so_oe_n_out),
  .array_addr_writable_out(array_addr_writable_out), .busy_out(busy_out),
  .write_enable_latch_out(write_enable_latch_out),
  .status_byte_out(status_byte_out),
  .nv_write_strobe_out(nv_write_strobe_out),
  .nv_write_data_out(nv_write_data_out));

// ==== dv/spi_master_model.sv ====
`timescale 1ns/1ps
module spi_master_model (
  input  wire logic clk_in,
  input  wire logic so_in,
  output logic      cs_n_out,
  output logic      sck_out,
  output logic      si_out
);
  initial begin
    cs_n_out = 1'b1;
    sck_out  = 1'b0;
    si_out   = 1'b0;
  end
  // Four system clocks per half gives the 320 ns link clock
  task automatic half;
    repeat (4) @(posedge clk_in);
  endtask
  // Mode 0, MSB first; SO sampled late in the high phase, where it stands
  task automatic xfer(input logic [15:0] tx, input int n,
                      output logic [7:0] rx);
    rx = 8'h00;
    @(posedge clk_in);
    cs_n_out <= 1'b0;
    for (int i = 0; i < n; i++) begin
      si_out <= tx[15-i];
      half();
      sck_out <= 1'b1;
      half();
      rx = {rx[6:0], so_in};
      sck_out <= 1'b0;
    end
    half();
    cs_n_out <= 1'b1;
    si_out <= ~si_out;
    repeat (8) @(posedge clk_in);
  endtask
endmodule

// ==== dv/tb_spi_eeprom_status_protect.sv ====
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
bad_count++; $display("ERROR %s exp %h got %h", n, e, g); end end
module tb_spi_eeprom_status_protect;
  typedef struct packed {
    logic [7:0]  d;
    logic [7:0]  s;
    logic [10:0] a;
    logic        w;
  } row_t;
  logic        clk_sys_in, reset_n_in, cs_n, sck, si, wp_n, so, oe_n;
  logic        ok, busy, latch;
  logic [10:0] addr;
  logic [7:0]  stat, rx;
  int          bad_count, total_checks;
  row_t        rows [7] = '{'{8'hF3, 8'h82, 11'h000, 1'b1},
    '{8'h04, 8'h06, 11'h5FF, 1'b1}, '{8'h04, 8'h06, 11'h600, 1'b0},
    '{8'h08, 8'h0A, 11'h3FF, 1'b1}, '{8'h08, 8'h0A, 11'h400, 1'b0},
    '{8'h7F, 8'h0E, 11'h000, 1'b0}, '{8'h00, 8'h02, 11'h7FF, 1'b1}};
  spi_master_model m (.clk_in(clk_sys_in), .so_in(so), .cs_n_out(cs_n),
    .sck_out(sck), .si_out(si));
  spi_eeprom_status_protect #(.WRITE_CYCLES(400)) uut (
    .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .spi_cs_n_in(cs_n),
    .spi_sck_in(sck), .spi_si_in(si), .protect_pin_n_in(wp_n),
    .spi_so_out(so), .spi_so_oe_n_out(oe_n), .array_addr_in(addr),
    .array_write_start_in(1'b0), .array_write_done_in(1'b0),
    .array_addr_writable_out(ok), .busy_out(busy),
    .write_enable_latch_out(latch), .status_byte_out(stat),
    .nv_write_strobe_out(), .nv_write_data_out());
  task automatic op(input logic [7:0] c);
    m.xfer({c, 8'h00}, 8, rx);
  endtask
  task automatic write_status_cmd(input logic [7:0] d);
    m.xfer({8'h01, d}, 16, rx);
  endtask
  task automatic read_status_cmd;
    m.xfer(16'h0500, 16, rx);
  endtask
  task automatic settle;
    for (int i = 0; i < 600 && busy !== 1'b0; i++) @(posedge clk_sys_in);
    repeat (8) @(posedge clk_sys_in);
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    clk_sys_in = 1'b0;
    forever #20 clk_sys_in = ~clk_sys_in;
  end
  initial begin
    repeat (30000) @(posedge clk_sys_in);
    bad_count++;
    report_and_stop();
  end
  initial begin
    reset_n_in = 1'b0;
    wp_n = 1'b1;
    addr = 11'h000;
    repeat (4) @(posedge clk_sys_in);
    reset_n_in <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    `CHK("status reset", 8'h00, stat)
    `CHK("so released", 1'b1, oe_n)
    foreach (rows[i]) begin
      op(8'h06);
      write_status_cmd(rows[i].d);
      settle();
      op(8'h06);
      addr <= rows[i].a;
      read_status_cmd();
      `CHK("read_status_cmd", rows[i].s, rx)
      `CHK("status", rows[i].s, stat)
      `CHK("writable", rows[i].w, ok)
    end
    op(8'h04);
    write_status_cmd(8'h0C);
    settle();
    `CHK("no latch", 8'h00, stat)
    op(8'h06);
    write_status_cmd(8'h80);
    read_status_cmd();
    `CHK("busy read", 8'h73, rx)
    op(8'h04);
    `CHK("busy ignore", 1'b1, latch)
    settle();
    `CHK("cycle end", 8'h80, stat)
    wp_n <= 1'b0;
    op(8'h0E);
    write_status_cmd(8'h00);
    settle();
    `CHK("hw protect", 8'h82, stat)
    op(8'h04);
    `CHK("clear latch", 1'b0, latch)
    wp_n <= 1'b1;
    op(8'h06);
    write_status_cmd(8'h00);
    settle();
    `CHK("pin high", 8'h00, stat)
    report_and_stop();
  end
endmodule
